// ### hw/lpsd_core.sv
// Command decoder and protocol state of the LP SDRAM
`timescale 1ns/10ps
`default_nettype none
module lpsd_core #(
	parameter int SR_INTERVAL = lpsd_pkg::SR_INT_CYC,
	parameter int FIFO_DEPTH = 8
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// Command pins, sampled on the rising edge
	input wire lpsd_pkg::lpsd_cmd_s cmdIn,
	// Data lanes, split drive
	input wire logic [lpsd_pkg::DQ_W-1:0] dqIn,
	output logic [lpsd_pkg::DQ_W-1:0] dqOut,
	output logic [1:0] dqOe,
	// Array access port
	output logic accValid,
	output lpsd_pkg::lpsd_acc_s accWr,
	input wire logic accReady,
	output logic [lpsd_pkg::COL_W-1:0] rdCol,
	output logic [1:0] rdBank,
	input wire logic [lpsd_pkg::DQ_W-1:0] rdData,
	// Status
	output logic [3:0] bankOpen,
	output logic [lpsd_pkg::OPC_W-1:0] modeReg,
	output logic [lpsd_pkg::OPC_W-1:0] extModeReg,
	output logic [lpsd_pkg::ROW_W-1:0] refRow,
	output logic selfRefresh,
	output logic deepPowerDown,
	output logic dataLost,
	output logic wrOverrun
);
	localparam int RC_W = 12;
	lpsd_pkg::lpsd_cmd_s c;
	logic [2:0] strobes;
	logic sel;
	logic actCmd, rdCmd, wrCmd, bstCmd, preCmd, refCmd, mrsCmd, srCmd, dpdCmd;
	logic [lpsd_pkg::ROW_W-1:0] openRow_r [4];
	logic [3:0] bankOpen_r;
	logic [4:0] preCnt_r [4];
	logic [lpsd_pkg::OPC_W-1:0] mode_r, emode_r;
	logic [lpsd_pkg::ROW_W-1:0] refRow_r;
	lpsd_pkg::lpsd_pwr_e pwr_r;
	logic [RC_W-1:0] pwrCnt_r;
	logic [RC_W-1:0] srAge_r;
	logic accLoad;
	logic busy_r, bRd_r, bAp_r;
	logic [1:0] bBank_r;
	logic [lpsd_pkg::COL_W-1:0] bCol_r;
	logic [9:0] bLeft_r;
	logic [1:0] rdMask1_r, rdMask2_r, rdAct1_r, rdAct2_r;
	logic [lpsd_pkg::DQ_W-1:0] rdData_r;
	logic [9:0] blen;
	logic wrBeat, fifoReady, fifoValid, apFire;
	lpsd_pkg::lpsd_acc_s wrBeatData, fifoOut;
	logic lostFlag_r, ovr_r;

	// Burst length from mode bits 2:0; write burst mode bit 9
	function automatic logic [9:0] burstLen(input logic [2:0] bl);
		return (bl == lpsd_pkg::BL_FULL) ? 10'(lpsd_pkg::BL_CAP)
			: 10'(1) << bl[1:0];
	endfunction

	// Decode; deselect and low-power modes hide all commands
	assign c = cmdIn;
	assign strobes = {c.rasN, c.casN, c.weN};
	assign sel = !c.csN && (pwr_r == lpsd_pkg::LPSD_IDLE);
	assign actCmd = sel && c.cke && strobes == lpsd_pkg::CMD_ACT;
	assign rdCmd = sel && c.cke && strobes == lpsd_pkg::CMD_RD;
	assign wrCmd = sel && c.cke && strobes == lpsd_pkg::CMD_WR;
	assign bstCmd = sel && c.cke && strobes == lpsd_pkg::CMD_BST;
	assign preCmd = sel && c.cke && strobes == lpsd_pkg::CMD_PRE;
	assign refCmd = sel && c.cke && strobes == lpsd_pkg::CMD_REF;
	assign mrsCmd = sel && c.cke && strobes == lpsd_pkg::CMD_MRS;
	assign srCmd = sel && !c.cke && strobes == lpsd_pkg::CMD_REF;
	assign dpdCmd = sel && !c.cke && strobes == lpsd_pkg::CMD_BST;
	assign blen = burstLen(mode_r[2:0]);
	// Auto-precharge fires on the tracker's last count (a write's last beat is a cycle earlier), never in full page
	assign apFire = busy_r && bAp_r && bLeft_r == 10'h001
		&& mode_r[2:0] != lpsd_pkg::BL_FULL;

	// Bank open state, open row and precharge timers
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			bankOpen_r <= 4'h0;
			for (int b = 0; b < 4; b++) begin
				openRow_r[b] <= '0;
				preCnt_r[b] <= '0;
			end
		end else begin
			for (int b = 0; b < 4; b++) begin
				if (preCnt_r[b] != '0) begin
					preCnt_r[b] <= preCnt_r[b] - 5'h01;
				end
				if (actCmd && c.bank == 2'(b) && !bankOpen_r[b]
						&& preCnt_r[b] == '0) begin
					bankOpen_r[b] <= 1'b1;
					openRow_r[b] <= c.addr;
				end
				if ((preCmd && (c.addr[lpsd_pkg::AP_BIT] || c.bank == 2'(b)))
						|| (apFire && bBank_r == 2'(b))) begin
					bankOpen_r[b] <= 1'b0;
					preCnt_r[b] <= 5'(lpsd_pkg::PRE_CYC);
				end
			end
			if (dpdCmd) begin
				bankOpen_r <= 4'h0;
			end
		end
	end

	// Burst tracker; newest read or write to an open bank replaces any running one
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			busy_r <= 1'b0;
			bRd_r <= 1'b0;
			bAp_r <= 1'b0;
			bBank_r <= '0;
			bCol_r <= '0;
			bLeft_r <= '0;
		end else if ((rdCmd || wrCmd) && bankOpen_r[c.bank]) begin
			busy_r <= 1'b1;
			bRd_r <= rdCmd;
			bAp_r <= c.addr[lpsd_pkg::AP_BIT];
			bBank_r <= c.bank;
			bCol_r <= c.addr[lpsd_pkg::COL_W-1:0];
			bLeft_r <= (wrCmd && mode_r[9]) ? 10'h001 : blen;
		end else if (bstCmd) begin
			busy_r <= 1'b0;
		end else if (busy_r) begin
			bCol_r <= bCol_r + 1'b1;
			bLeft_r <= bLeft_r - 10'h001;
			busy_r <= !(bLeft_r == 10'h001 && mode_r[2:0] != lpsd_pkg::BL_FULL);
		end
	end

	// Write beat: data and mask in the same cycle, then queued
	// Command cycle is the first beat, so the tracker's last count is idle
	assign wrBeat = (wrCmd && bankOpen_r[c.bank]) || (busy_r && !bRd_r && !bstCmd
		&& !rdCmd && !wrCmd && (bLeft_r != 10'h001
		|| mode_r[2:0] == lpsd_pkg::BL_FULL));
	assign wrBeatData = {wrCmd ? c.bank : bBank_r,
		openRow_r[wrCmd ? c.bank : bBank_r],
		wrCmd ? c.addr[lpsd_pkg::COL_W-1:0] : bCol_r,
		dqIn, ~c.dqm};

	lpsd_fifo #(
		.WIDTH($bits(lpsd_pkg::lpsd_acc_s)),
		.DEPTH(FIFO_DEPTH)
	) u_wrFifo (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.inValid(wrBeat),
		.inReady(fifoReady),
		.inData(wrBeatData),
		.outValid(fifoValid),
		.outReady(accLoad),
		.outData(fifoOut)
	);

	// Output stage reloads only when empty or taken, so no beat is lost
	assign accLoad = !accValid || accReady;
	// Array write port registered; drops flagged when the queue is full
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			accValid <= 1'b0;
			accWr <= '0;
			ovr_r <= 1'b0;
		end else begin
			if (accLoad) begin
				accValid <= fifoValid;
				if (fifoValid) begin
					accWr <= fifoOut;
				end
			end
			if (wrBeat && !fifoReady) begin
				ovr_r <= 1'b1;
			end
		end
	end

	// Read path: mask pipelined two clocks before gating the lanes
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			rdMask1_r <= 2'h3;
			rdMask2_r <= 2'h3;
			rdAct1_r <= 2'h0;
			rdAct2_r <= 2'h0;
			rdData_r <= '0;
			dqOut <= '0;
			dqOe <= 2'h0;
			rdCol <= '0;
			rdBank <= '0;
		end else begin
			rdMask1_r <= c.dqm;
			rdMask2_r <= rdMask1_r;
			rdAct1_r <= {2{busy_r && bRd_r && !bstCmd}};
			rdAct2_r <= rdAct1_r;
			rdCol <= bCol_r;
			rdBank <= bBank_r;
			rdData_r <= rdData;
			dqOut <= rdData_r;
			dqOe <= rdAct2_r & ~rdMask2_r;
		end
	end

	// Mode registers; bank lines choose base or extended
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			mode_r <= lpsd_pkg::MODE_RST;
			emode_r <= lpsd_pkg::MODE_RST;
		end else if (mrsCmd && bankOpen_r == 4'h0) begin
			if (c.bank == lpsd_pkg::BANK_EXT) begin
				emode_r <= c.addr[lpsd_pkg::OPC_W-1:0];
			end else if (c.bank == 2'h0) begin
				mode_r <= c.addr[lpsd_pkg::OPC_W-1:0];
			end
		end
	end

	// Power state and internal refresh counter shared by both refreshes
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			pwr_r <= lpsd_pkg::LPSD_IDLE;
			pwrCnt_r <= '0;
			srAge_r <= '0;
			refRow_r <= '0;
			lostFlag_r <= 1'b0;
		end else begin
			if (refCmd) begin
				refRow_r <= refRow_r + 1'b1;
			end
			case (pwr_r)
				lpsd_pkg::LPSD_IDLE: begin
					if (srCmd) begin
						pwr_r <= lpsd_pkg::LPSD_SREF;
						pwrCnt_r <= '0;
						srAge_r <= '0;
					end else if (dpdCmd) begin
						pwr_r <= lpsd_pkg::LPSD_DPD;
						lostFlag_r <= 1'b1;
					end
				end
				lpsd_pkg::LPSD_SREF: begin
					// Residence has its own saturating count; the
					// refresh tick wraps and cannot measure it
					if (srAge_r != RC_W'(lpsd_pkg::RAS_CYC)) begin
						srAge_r <= srAge_r + 1'b1;
					end
					pwrCnt_r <= (pwrCnt_r == RC_W'(SR_INTERVAL)) ? '0
						: pwrCnt_r + 1'b1;
					if (pwrCnt_r == RC_W'(SR_INTERVAL)) begin
						refRow_r <= refRow_r + 1'b1;
					end
					if (c.cke && srAge_r == RC_W'(lpsd_pkg::RAS_CYC)) begin
						pwr_r <= lpsd_pkg::LPSD_SRX;
						pwrCnt_r <= RC_W'(lpsd_pkg::XSR_CYC);
					end
				end
				lpsd_pkg::LPSD_SRX: begin
					pwrCnt_r <= pwrCnt_r - 1'b1;
					if (pwrCnt_r == RC_W'(1)) begin
						pwr_r <= lpsd_pkg::LPSD_IDLE;
					end
				end
				lpsd_pkg::LPSD_DPD: begin
					// Leave on enable high; array content is gone
					if (c.cke) begin
						pwr_r <= lpsd_pkg::LPSD_IDLE;
					end
				end
				default: pwr_r <= lpsd_pkg::LPSD_IDLE;
			endcase
			if (mrsCmd) begin
				lostFlag_r <= 1'b0;
			end
		end
	end

	// Status outputs from flops
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			bankOpen <= 4'h0;
			modeReg <= lpsd_pkg::MODE_RST;
			extModeReg <= lpsd_pkg::MODE_RST;
			refRow <= '0;
			selfRefresh <= 1'b0;
			deepPowerDown <= 1'b0;
			dataLost <= 1'b0;
			wrOverrun <= 1'b0;
		end else begin
			bankOpen <= bankOpen_r;
			modeReg <= mode_r;
			extModeReg <= emode_r;
			refRow <= refRow_r;
			selfRefresh <= pwr_r == lpsd_pkg::LPSD_SREF;
			deepPowerDown <= pwr_r == lpsd_pkg::LPSD_DPD;
			dataLost <= lostFlag_r;
			wrOverrun <= ovr_r;
		end
	end
endmodule
`default_nettype wire

// ### hw/lpsd_pkg.sv
// Package with command codes, field layouts and timing counts for the LP SDRAM core
package lpsd_pkg;
	localparam int ROW_W = 13;
	localparam int COL_W = 9;
	localparam int DQ_W = 16;
	localparam int OPC_W = 10;
	localparam int AP_BIT = 10;
	// Strobe patterns {row, column, write}
	localparam logic [2:0] CMD_NOP = 3'h7;
	localparam logic [2:0] CMD_ACT = 3'h3;
	localparam logic [2:0] CMD_RD = 3'h5;
	localparam logic [2:0] CMD_WR = 3'h4;
	localparam logic [2:0] CMD_BST = 3'h6;
	localparam logic [2:0] CMD_PRE = 3'h2;
	localparam logic [2:0] CMD_REF = 3'h1;
	localparam logic [2:0] CMD_MRS = 3'h0;
	localparam logic [1:0] BANK_EXT = 2'h2;
	localparam logic [2:0] BL_FULL = 3'h7;
	localparam logic [OPC_W-1:0] MODE_RST = 10'h000;
	// Timing figures in ns, derived counts at 4 ns clock
	localparam int CLK_NS = 4;
	localparam int PRECHARGE_PERIOD_NS = 18;
	localparam int PRE_CYC = (PRECHARGE_PERIOD_NS + CLK_NS - 1) / CLK_NS;
	localparam int ROW_ACTIVE_MIN_NS = 42;
	localparam int RAS_CYC = (ROW_ACTIVE_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int SR_EXIT_NS = 120;
	localparam int XSR_CYC = (SR_EXIT_NS + CLK_NS - 1) / CLK_NS;
	localparam int SR_INT_CYC = 1953;
	localparam int BL_CAP = 512;
	typedef enum logic [2:0] {
		LPSD_IDLE = 3'h0,
		LPSD_SREF = 3'h1,
		LPSD_SRX = 3'h3,
		LPSD_DPD = 3'h2
	} lpsd_pwr_e;
	typedef struct packed {
		logic cke;
		logic csN;
		logic rasN;
		logic casN;
		logic weN;
		logic [1:0] dqm;
		logic [1:0] bank;
		logic [ROW_W-1:0] addr;
	} lpsd_cmd_s;
	typedef struct packed {
		logic [1:0] bank;
		logic [ROW_W-1:0] row;
		logic [COL_W-1:0] col;
		logic [DQ_W-1:0] data;
		logic [1:0] be;
	} lpsd_acc_s;
endpackage

// ### hw/lpsd_fifo.sv
// Parameterised valid/ready FIFO used on the write data path
`timescale 1ns/10ps
`default_nettype none
module lpsd_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// Fill side
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	// Drain side
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wPtr_r;
	logic [AW-1:0] rPtr_r;
	logic [AW:0] cnt_r;
	logic push;
	logic pop;
	// Honest flags straight from the count
	assign inReady = (cnt_r != (AW+1)'(DEPTH));
	assign outValid = (cnt_r != '0);
	assign outData = mem[rPtr_r];
	assign push = inValid && inReady;
	assign pop = outValid && outReady;
	// Storage written without reset, pointers guard it
	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wPtr_r] <= inData;
		end
	end
	// Pointer and occupancy bookkeeping
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			wPtr_r <= '0;
			rPtr_r <= '0;
			cnt_r <= '0;
		end else begin
			if (push) begin
				wPtr_r <= (wPtr_r == AW'(DEPTH-1)) ? '0 : wPtr_r + 1'b1;
			end
			if (pop) begin
				rPtr_r <= (rPtr_r == AW'(DEPTH-1)) ? '0 : rPtr_r + 1'b1;
			end
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule
`default_nettype wire

// ### bench/lpsd_core_monitor.sv
// Checker of command decode effects seen at the core's ports
`timescale 1ns/10ps
`default_nettype none
module lpsd_core_monitor #(
	parameter int SR_INTERVAL = lpsd_pkg::SR_INT_CYC,
	parameter int FIFO_DEPTH = 8
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// Command pins
	input wire lpsd_pkg::lpsd_cmd_s cmdIn,
	// Status
	input wire logic [3:0] bankOpen,
	input wire logic [lpsd_pkg::OPC_W-1:0] modeReg,
	input wire logic [lpsd_pkg::OPC_W-1:0] extModeReg,
	input wire logic selfRefresh,
	input wire logic deepPowerDown
);
	logic [2:0] op;
	logic go;
	// Decode only while awake; status lags, so asleep is judged late
	assign op = {cmdIn.rasN, cmdIn.casN, cmdIn.weN};
	assign go = !cmdIn.csN && !selfRefresh && !deepPowerDown;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	sequence deselected;
		cmdIn.csN;
	endsequence
	sequence modeLoad;
		go && cmdIn.cke && op == lpsd_pkg::CMD_MRS && bankOpen == 4'h0;
	endsequence
	new_row_a: assert property (
		(bankOpen & ~$past(bankOpen)) != 4'h0
		|-> $past(go && cmdIn.cke && op == lpsd_pkg::CMD_ACT, 2))
		else $error("bank opened without activate");
	pre_all_a: assert property (
		go && cmdIn.cke && op == lpsd_pkg::CMD_PRE && cmdIn.addr[10]
		|-> ##2 bankOpen == 4'h0)
		else $error("precharge all left a bank open");
	pre_one_a: assert property (
		go && cmdIn.cke && op == lpsd_pkg::CMD_PRE && !cmdIn.addr[10]
		|-> ##2 !bankOpen[$past(cmdIn.bank, 2)])
		else $error("precharge left its bank open");
	mode_norm_a: assert property (
		modeLoad ##0 cmdIn.bank == 2'h0
		|-> ##2 modeReg == $past(cmdIn.addr[9:0], 2))
		else $error("mode register not loaded");
	mode_ext_a: assert property (
		modeLoad ##0 cmdIn.bank == lpsd_pkg::BANK_EXT
		|-> ##2 extModeReg == $past(cmdIn.addr[9:0], 2))
		else $error("extended mode register not loaded");
	cs_block_a: assert property (
		deselected |-> ##2 $stable(modeReg) && $stable(extModeReg))
		else $error("deselected command changed mode");
	sref_enter_a: assert property (
		go && !cmdIn.cke && op == lpsd_pkg::CMD_REF |-> ##2 selfRefresh)
		else $error("self refresh not entered");
	dpd_enter_a: assert property (
		go && !cmdIn.cke && op == lpsd_pkg::CMD_BST |-> ##2 deepPowerDown)
		else $error("deep power down not entered");
endmodule
bind lpsd_core lpsd_core_monitor #(
	.SR_INTERVAL(SR_INTERVAL),
	.FIFO_DEPTH(FIFO_DEPTH)
) u_mon (.clk_sys, .rstn, .cmdIn, .bankOpen, .modeReg, .extModeReg,
	.selfRefresh, .deepPowerDown);
`default_nettype wire

// ### bench/lpsd_host_model.sv
// Host controller model: drives command pins, holds the array store
`timescale 1ns/10ps
`default_nettype none
module lpsd_host_model (
	// Clock and pacing of the array side
	input wire logic clk_sys,
	input wire logic [1:0] pace,
	// Command and data pins
	output lpsd_pkg::lpsd_cmd_s cmdOut,
	output logic [15:0] dq,
	// Array port
	input wire logic accValid,
	input wire lpsd_pkg::lpsd_acc_s accWr,
	output logic accReady,
	input wire logic [8:0] rdCol,
	input wire logic [1:0] rdBank,
	output logic [15:0] rdData
);
	logic [15:0] mem [0:2047];
	logic [1:0] tick = 2'h0;
	logic [3:0] openBank = 4'h0;
	lpsd_pkg::lpsd_acc_s got[$];
	initial begin
		cmdOut = {2'h2, lpsd_pkg::CMD_NOP, 17'h0};
		dq = 16'h0;
		accReady = 1'b0;
	end
	// One command per cycle, then a no-op whose loose lines toggle;
	// the mask stays, as it gates read lanes two clocks on
	task automatic send(input lpsd_pkg::lpsd_cmd_s c, input logic [15:0] d);
		@(negedge clk_sys);
		cmdOut = c;
		dq = d;
		if (!c.csN && {c.rasN, c.casN, c.weN} == lpsd_pkg::CMD_ACT)
			openBank[c.bank] = 1'b1;
		if (!c.csN && {c.rasN, c.casN, c.weN} == lpsd_pkg::CMD_PRE)
			openBank = c.addr[10] ? 4'h0 : openBank & ~(4'h1 << c.bank);
		@(negedge clk_sys);
		cmdOut = {c.cke, 1'b0, lpsd_pkg::CMD_NOP, c.dqm, ~c.bank, ~c.addr};
		dq = ~d;
	endtask
	// Ready pacing: prompt, one edge in four, or held off
	always @(negedge clk_sys) begin
		tick <= tick + 2'h1;
		accReady <= pace == 2'h0 || (pace == 2'h1 && tick == 2'h0);
	end
	// Accepted beats are logged and merged lane by lane
	always @(posedge clk_sys) begin
		if (accValid && accReady) begin
			got.push_back(accWr);
			if (accWr.be[0])
				mem[{accWr.bank, accWr.col}][7:0] <= accWr.data[7:0];
			if (accWr.be[1])
				mem[{accWr.bank, accWr.col}][15:8] <= accWr.data[15:8];
		end
	end
	assign rdData = mem[{rdBank, rdCol}];
endmodule
`default_nettype wire

// ### bench/tb_lpsd_core.sv
// Self-checking bench for the command core of the LP SDRAM
`timescale 1ns/10ps
`default_nettype none
module tb_lpsd_core;
	localparam int SRI = 16;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic [1:0] pace = 2'h0;
	logic sawOvr = 1'b0;
	logic [31:0] lfsr = 32'hECD7;
	int error_cnt = 0;
	int num_checks = 0;
	lpsd_pkg::lpsd_cmd_s cmdIn;
	lpsd_pkg::lpsd_acc_s accWr;
	logic [15:0] dqIn, dqOut, rdData;
	logic [1:0] dqOe, rdBank;
	logic [8:0] rdCol;
	logic [3:0] bankOpen;
	logic [9:0] modeReg, extModeReg;
	logic [12:0] refRow;
	logic accValid, accReady, selfRefresh, deepPowerDown, dataLost;
	logic wrOverrun;
	initial forever #2 clk_sys = ~clk_sys;
	lpsd_core #(.SR_INTERVAL(SRI)) u_dut (.clk_sys, .rstn, .cmdIn, .dqIn,
		.dqOut, .dqOe, .accValid, .accWr, .accReady, .rdCol, .rdBank,
		.rdData, .bankOpen, .modeReg, .extModeReg, .refRow, .selfRefresh,
		.deepPowerDown, .dataLost, .wrOverrun);
	lpsd_host_model u_host (.clk_sys, .pace, .cmdOut(cmdIn), .dq(dqIn),
		.accValid, .accWr, .accReady, .rdCol, .rdBank, .rdData);
	// Overrun is sticky until reset; remember it anyway
	always @(posedge clk_sys)
		if (wrOverrun === 1'b1) sawOvr <= 1'b1;
	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction
	// Lanes that a two-bit mask leaves live
	function automatic logic [15:0] live(input logic [1:0] m);
		return {{8{!m[1]}}, {8{!m[0]}}};
	endfunction
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic stop_test();
		if (error_cnt == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// ks is {clock enable, chip select}
	task automatic cmd(input logic [1:0] ks, input logic [2:0] op,
		input logic [1:0] bk, input logic [12:0] a, input logic [1:0] mk,
		input logic [15:0] d);
		u_host.send({ks, op, mk, bk, a}, d);
	endtask
	task automatic nops(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task automatic waitGot(input int n);
		for (int t = 0; t < 200; t++) begin
			if (u_host.got.size() >= n)
				return;
			@(negedge clk_sys);
		end
		error_cnt++;
		stop_test();
	endtask
	initial begin
		logic [1:0] b, m;
		logic [8:0] col;
		logic [15:0] d;
		logic [12:0] r, row;
		int k;
		repeat (16) @(negedge clk_sys);
		rstn = 1'b1;
		check("bankOpen", bankOpen, 0);
		d = {6'h0, 7'(rnd() >> 3), 3'h0};
		cmd(2'h2, lpsd_pkg::CMD_MRS, 2'h0, d[12:0], 2'h0, 16'h0);
		r = 13'(rnd());
		cmd(2'h2, lpsd_pkg::CMD_MRS, lpsd_pkg::BANK_EXT, r, 2'h0, 16'h0);
		cmd(2'h2, lpsd_pkg::CMD_MRS, 2'h1, ~r, 2'h0, 16'h0);
		cmd(2'h3, lpsd_pkg::CMD_MRS, 2'h0, ~r, 2'h0, 16'h0);
		b = 2'(rnd());
		cmd(2'h3, lpsd_pkg::CMD_ACT, b, 13'h0, 2'h0, 16'h0);
		nops(2);
		check("modeReg", modeReg, d[9:0]);
		check("extModeReg", extModeReg, r[9:0]);
		check("bankOpen", bankOpen, 0);
		row = 13'(rnd());
		cmd(2'h2, lpsd_pkg::CMD_ACT, b, row, 2'h0, 16'h0);
		nops(2);
		check("bankOpen", bankOpen, 4'h1 << b);
		// Write then read back, prompt and slow array, top column first
		for (int i = 0; i < 6; i++) begin
			pace = 2'(i % 2);
			col = i == 0 ? 9'h1FF : 9'(rnd());
			m = 2'(i % 3);
			d = 16'(rnd());
			k = u_host.got.size();
			cmd(2'h2, lpsd_pkg::CMD_WR, b, {4'h0, col}, m, d);
			waitGot(k + 1);
			check("wrAddr", {u_host.got[k].bank, u_host.got[k].row,
				u_host.got[k].col}, {b, row, col});
			check("wrBe", u_host.got[k].be, 2'(~m));
			check("wrData", u_host.got[k].data & live(m), d & live(m));
			cmd(2'h2, lpsd_pkg::CMD_RD, b, {4'h0, col}, m, 16'h0);
			for (int t = 0; t < 8 && dqOe === 2'h0; t++)
				@(negedge clk_sys);
			check("dqOe", dqOe, 2'(~m));
			check("dqOut", dqOut & live(m), d & live(m));
		end
		k = u_host.got.size();
		cmd(2'h2, lpsd_pkg::CMD_WR, b + 2'h1, 13'h0, 2'h0, 16'h0);
		nops(8);
		check("closedWr", u_host.got.size(), k);
		// Hold the array off until the write buffer refuses
		pace = 2'h2;
		for (int i = 0; i < 16; i++)
			cmd(2'h2, lpsd_pkg::CMD_WR, b, 13'(i), 2'h0, 16'h1000 + 16'(i));
		check("overrun", sawOvr, 1);
		pace = 2'h1;
		waitGot(k + 8);
		for (int i = 0; i < 8; i++)
			check("fifoData", u_host.got[k + i].data, 16'h1000 + i);
		nops(60);
		check("drained", accValid, 0);
		pace = 2'h0;
		cmd(2'h2, lpsd_pkg::CMD_WR, b, 13'h400, 2'h0, 16'h0);
		nops(12);
		check("autoPre", bankOpen[b], 0);
		cmd(2'h2, lpsd_pkg::CMD_ACT, b, row, 2'h0, 16'h0);
		cmd(2'h2, lpsd_pkg::CMD_PRE, b, 13'h0, 2'h0, 16'h0);
		cmd(2'h2, lpsd_pkg::CMD_ACT, b, row, 2'h0, 16'h0);
		nops(2);
		check("actInPre", bankOpen[b], 0);
		nops(6);
		cmd(2'h2, lpsd_pkg::CMD_ACT, b, row, 2'h0, 16'h0);
		cmd(2'h2, lpsd_pkg::CMD_ACT, b + 2'h2, row, 2'h0, 16'h0);
		nops(2);
		check("reopen", bankOpen, (4'h1 << b) | (4'h1 << (b + 2'h2)));
		d = {6'h0, modeReg};
		cmd(2'h2, lpsd_pkg::CMD_MRS, 2'h0, ~d[12:0], 2'h0, 16'h0);
		nops(2);
		check("modeWhileOpen", modeReg, d[9:0]);
		cmd(2'h2, lpsd_pkg::CMD_PRE, 2'(rnd()), 13'h400, 2'h0, 16'h0);
		nops(8);
		check("preAll", bankOpen, 0);
		r = refRow;
		// Two refreshes back to back, as after power-up
		cmd(2'h2, lpsd_pkg::CMD_REF, 2'h0, 13'h0, 2'h0, 16'h0);
		cmd(2'h2, lpsd_pkg::CMD_REF, 2'h0, 13'h0, 2'h0, 16'h0);
		nops(4);
		check("refRow", refRow, 13'(r + 13'h2));
		cmd(2'h0, lpsd_pkg::CMD_REF, 2'h0, 13'h0, 2'h0, 16'h0);
		nops(2);
		check("selfRefresh", selfRefresh, 1);
		r = refRow;
		cmd(2'h0, lpsd_pkg::CMD_ACT, b, row, 2'h0, 16'h0);
		nops(SRI * 3);
		check("srRows", refRow !== r, 1);
		cmd(2'h2, lpsd_pkg::CMD_NOP, 2'h0, 13'h0, 2'h0, 16'h0);
		nops(lpsd_pkg::XSR_CYC + 2);
		check("srExit", {selfRefresh, bankOpen}, 0);
		r = refRow;
		cmd(2'h2, lpsd_pkg::CMD_REF, 2'h0, 13'h0, 2'h0, 16'h0);
		nops(2);
		check("refAfterSr", refRow, 13'(r + 13'h1));
		cmd(2'h0, lpsd_pkg::CMD_BST, 2'h0, 13'h0, 2'h0, 16'h0);
		nops(2);
		check("dpd", {deepPowerDown, dataLost}, 2'h3);
		cmd(2'h2, lpsd_pkg::CMD_NOP, 2'h0, 13'h0, 2'h0, 16'h0);
		nops(4);
		check("dpdExit", {deepPowerDown, dataLost}, 2'h1);
		cmd(2'h2, lpsd_pkg::CMD_MRS, 2'h0, 13'h0, 2'h0, 16'h0);
		nops(2);
		check("reinit", dataLost, 0);
		stop_test();
	end
endmodule
`default_nettype wire
